// ### core/system_clock_source_select.sv
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select
  import clk_sel_pkg::*;
#(
  parameter int unsigned STARTUP_COUNT = clk_sel_pkg::STARTUP_COUNT_DEF
)(
  input  wire logic                           sys_clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic [2:0]                     fosc_cfg_i,
  input  wire logic                           clock_out_enable_n_i,
  input  wire logic [1:0]                     system_clock_select_i,
  input  wire logic [1:0]                     int_osc_select_i,
  input  wire logic [clk_sel_pkg::TUNE_W-1:0] osc_tuning_register_i,
  input  wire logic                           primary_oscillator_pin_i,
  input  wire logic                           sec_timer_osc_i,
  input  wire logic                           secondary_oscillator_pin_i,
  input  wire logic                           gpio_sec_out_i,
  input  wire logic                           gpio_sec_oe_n_i,
  output logic                                system_clock_o,
  output clk_sel_pkg::src_t                   active_source_o,
  output logic                                switch_busy_o,
  output clk_sel_pkg::gain_t                  amp_gain_o,
  output clk_sel_pkg::ext_power_t             ext_power_o,
  output logic                                startup_timer_en_o,
  output logic                                startup_done_o,
  output logic                                primary_pin_gpio_o,
  output logic                                secondary_oscillator_pin_o,
  output logic                                secondary_oscillator_pin_oe_n_o,
  output logic                                gpio_sec_in_o
);
  import clk_sel_pkg::*;

  if (STARTUP_COUNT == 0 || STARTUP_COUNT >= (1 << STARTUP_CNT_W))
  begin : g_bad_startup
    $error("STARTUP_COUNT out of range for the startup counter");
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic prim_s1_q, prim_s2_q, sec_s1_q, sec_s2_q, pin2_s1_q, pin2_s2_q, prim_prev_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {prim_s1_q, prim_s2_q, prim_prev_q} <= 3'h0;
      {sec_s1_q, sec_s2_q, pin2_s1_q, pin2_s2_q} <= 4'h0;
    end
    else
    begin
      prim_s1_q   <= primary_oscillator_pin_i;
      prim_s2_q   <= prim_s1_q;
      prim_prev_q <= prim_s2_q;
      sec_s1_q    <= sec_timer_osc_i;
      sec_s2_q    <= sec_s1_q;
      pin2_s1_q   <= secondary_oscillator_pin_i;
      pin2_s2_q   <= pin2_s1_q;
    end
  end

  function automatic logic is_crystal(input logic [2:0] f);
    return (f == FOSC_XTAL_LOW) || (f == FOSC_XTAL_MID) || (f == FOSC_XTAL_HIGH);
  endfunction

  function automatic logic is_ext_clk(input logic [2:0] f);
    return (f == FOSC_EXT_LOW) || (f == FOSC_EXT_MED) || (f == FOSC_EXT_HIGH);
  endfunction

  // --------------------------------------------------------------------------
  // internal oscillators
  // --------------------------------------------------------------------------
  logic [MF_CNT_W-1:0] mf_cnt_q, mf_cnt_d, mf_half_w;
  logic [LF_CNT_W-1:0] lf_cnt_q, lf_cnt_d;
  logic [PHASE_W-1:0]  hf_acc_q, hf_acc_d, hf_inc_w;
  logic                mf_q, mf_d, lf_q, lf_d;

  // trim moves both the reference half period and the pll step together
  assign mf_half_w = MF_HALF_CYC - {{(MF_CNT_W-TUNE_W){osc_tuning_register_i[TUNE_W-1]}},
                                    osc_tuning_register_i};
  assign hf_inc_w  = HF_PHASE_INC + PHASE_W'({{(PHASE_W-TUNE_W){osc_tuning_register_i[TUNE_W-1]}},
                                    osc_tuning_register_i} << HF_TUNE_SHIFT);

  always_comb
  begin
    mf_cnt_d = mf_cnt_q + 1'b1;
    mf_d     = mf_q;
    if (mf_cnt_q >= mf_half_w - 1'b1)
    begin
      mf_cnt_d = '0;
      mf_d     = ~mf_q;
    end
    lf_cnt_d = lf_cnt_q + 1'b1;
    lf_d     = lf_q;
    if (lf_cnt_q == LF_HALF_CYC - 1'b1)
    begin
      lf_cnt_d = '0;
      lf_d     = ~lf_q;
    end
    // pll: phase restarts on each reference rise, so it stays locked to it
    hf_acc_d = (mf_d && !mf_q) ? '0 : hf_acc_q + hf_inc_w;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mf_cnt_q <= '0;
      lf_cnt_q <= '0;
      hf_acc_q <= '0;
      mf_q     <= 1'b0;
      lf_q     <= 1'b0;
    end
    else
    begin
      mf_cnt_q <= mf_cnt_d;
      lf_cnt_q <= lf_cnt_d;
      hf_acc_q <= hf_acc_d;
      mf_q     <= mf_d;
      lf_q     <= lf_d;
    end
  end

  // --------------------------------------------------------------------------
  // config capture, startup timer, source switch
  // --------------------------------------------------------------------------
  logic [2:0]           cfg_q, cfg_d;
  logic                 cfg_valid_q;
  logic [STARTUP_CNT_W-1:0] stup_cnt_q, stup_cnt_d;
  logic                     stup_done_w;
  sw_state_t            st_q, st_d;
  src_t                 cur_q, cur_d, tgt_q, tgt_d, req_w;
  logic                 gated_q, gated_d;

  function automatic src_t req_source(input logic [2:0] f, input logic [1:0] system_clock_select,
                                      input logic [1:0] isel);
    src_t s;
    s = SRC_PRIMARY;
    if (system_clock_select[SEL_INT_BIT] || (system_clock_select == SEL_CONFIG && f == FOSC_INTERNAL))
      s = (isel == INT_SEL_LF) ? SRC_LF : (isel == INT_SEL_MF) ? SRC_MF : SRC_HF;
    else if (system_clock_select == SEL_SEC_TIMER)
      s = SRC_SECONDARY;
    return s;
  endfunction

  function automatic logic src_level(input src_t s, input logic p, input logic t,
                                     input logic h, input logic m, input logic l);
    case (s)
      SRC_PRIMARY:   return p;
      SRC_SECONDARY: return t;
      SRC_HF:        return h;
      SRC_MF:        return m;
      default:       return l;
    endcase
  endfunction

  assign req_w      = req_source(cfg_q, system_clock_select_i, int_osc_select_i);
  // no start-up wait unless a resonator must settle
  assign stup_done_w = !is_crystal(cfg_q)
                       || (stup_cnt_q == STARTUP_CNT_W'(STARTUP_COUNT));

  logic old_lvl_w, new_lvl_w;
  assign old_lvl_w = src_level(cur_q, prim_s2_q, sec_s2_q, hf_acc_q[PHASE_W-1], mf_q, lf_q);
  assign new_lvl_w = src_level(tgt_q, prim_s2_q, sec_s2_q, hf_acc_q[PHASE_W-1], mf_q, lf_q);

  always_comb
  begin
    cfg_d     = cfg_valid_q ? cfg_q : fosc_cfg_i;
    stup_cnt_d = stup_cnt_q;
    if (is_crystal(cfg_q) && !stup_done_w && prim_s2_q && !prim_prev_q)
      stup_cnt_d = stup_cnt_q + 1'b1;
    st_d    = st_q;
    cur_d   = cur_q;
    tgt_d   = tgt_q;
    gated_d = 1'b0;
    case (st_q)
      ST_LOAD:
      begin
        if (cfg_valid_q)
        begin
          tgt_d = req_w;
          st_d  = ST_NEW_LOW;
        end
      end
      ST_RUN:
      begin
        // no edge on the chosen source means no edge out: state simply holds
        gated_d = old_lvl_w;
        if (req_w != cur_q)
        begin
          tgt_d = req_w;
          st_d  = ST_OLD_LOW;
        end
      end
      ST_OLD_LOW:
      begin
        // let the running high phase finish rather than truncate it
        gated_d = gated_q && old_lvl_w;
        if (!old_lvl_w)
          st_d = ST_NEW_LOW;
      end
      ST_NEW_LOW:
      begin
        if (!new_lvl_w && (tgt_q != SRC_PRIMARY || stup_done_w))
        begin
          cur_d = tgt_q;
          st_d  = ST_RUN;
        end
      end
      default: st_d = ST_LOAD;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_q       <= FOSC_XTAL_LOW;
      cfg_valid_q <= 1'b0;
      stup_cnt_q  <= '0;
      st_q        <= ST_LOAD;
      cur_q       <= SRC_LF;
      tgt_q       <= SRC_LF;
      gated_q     <= 1'b0;
    end
    else
    begin
      cfg_q       <= cfg_d;
      cfg_valid_q <= 1'b1;
      stup_cnt_q  <= stup_cnt_d;
      st_q        <= st_d;
      cur_q       <= cur_d;
      tgt_q       <= tgt_d;
      gated_q     <= gated_d;
    end
  end

  // --------------------------------------------------------------------------
  // mode decode and pin functions
  // --------------------------------------------------------------------------
  gain_t      gain_d;
  ext_power_t ecp_d;
  logic       sec_out_d, sec_oe_n_d;

  always_comb
  begin
    case (cfg_q)
      FOSC_XTAL_LOW:  gain_d = GAIN_LOW;
      FOSC_XTAL_MID:  gain_d = GAIN_MID;
      FOSC_XTAL_HIGH: gain_d = GAIN_HIGH;
      default:        gain_d = GAIN_OFF;
    endcase
    case (cfg_q)
      FOSC_EXT_HIGH: ecp_d = EXT_PWR_HIGH;
      FOSC_EXT_MED:  ecp_d = EXT_PWR_MED;
      FOSC_EXT_LOW:  ecp_d = EXT_PWR_LOW;
      default:       ecp_d = EXT_PWR_NONE;
    endcase
    // resonator owns the pin in crystal modes, so nothing drives it
    if (is_crystal(cfg_q))
    begin
      sec_out_d  = 1'b0;
      sec_oe_n_d = 1'b1;
    end
    else if (!clock_out_enable_n_i)
    begin
      sec_out_d  = gated_d;
      sec_oe_n_d = 1'b0;
    end
    else
    begin
      sec_out_d  = gpio_sec_out_i;
      sec_oe_n_d = gpio_sec_oe_n_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      amp_gain_o                      <= GAIN_OFF;
      ext_power_o                     <= EXT_PWR_NONE;
      startup_timer_en_o              <= 1'b0;
      startup_done_o                  <= 1'b0;
      primary_pin_gpio_o              <= 1'b0;
      secondary_oscillator_pin_o      <= 1'b0;
      secondary_oscillator_pin_oe_n_o <= 1'b1;
      gpio_sec_in_o                   <= 1'b0;
      active_source_o                 <= SRC_LF;
      switch_busy_o                   <= 1'b1;
    end
    else
    begin
      amp_gain_o                      <= gain_d;
      ext_power_o                     <= ecp_d;
      startup_timer_en_o              <= is_crystal(cfg_q) && !stup_done_w;
      startup_done_o                  <= stup_done_w;
      primary_pin_gpio_o              <= (cfg_q == FOSC_INTERNAL);
      secondary_oscillator_pin_o      <= sec_out_d;
      secondary_oscillator_pin_oe_n_o <= sec_oe_n_d;
      gpio_sec_in_o                   <= pin2_s2_q;
      active_source_o                 <= cur_d;
      switch_busy_o                   <= (st_d != ST_RUN);
    end
  end

  assign system_clock_o = gated_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_ext_power;
    cfg_valid_q && cfg_q == FOSC_EXT_MED
      |=> ext_power_o == EXT_PWR_MED && amp_gain_o == GAIN_OFF;
  endproperty
  a_ext_power: assert property (p_ext_power) else $error("ext power decode wrong");

  property p_ext_no_startup;
    cfg_valid_q && is_ext_clk(cfg_q) |=> !startup_timer_en_o && startup_done_o;
  endproperty
  a_ext_no_startup: assert property (p_ext_no_startup) else $error("startup timer active");

  property p_static;
    st_q == ST_RUN && cur_q == SRC_PRIMARY && req_w == SRC_PRIMARY
      |=> system_clock_o == $past(prim_s2_q);
  endproperty
  a_static: assert property (p_static) else $error("clock does not follow pin");

  property p_cfg_load;
    $rose(cfg_valid_q) |-> cfg_q == $past(fosc_cfg_i) ##1 st_q == ST_NEW_LOW;
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config not taken at reset");

  property p_switch_start;
    st_q == ST_RUN && req_w != cur_q |=> st_q == ST_OLD_LOW && tgt_q == $past(req_w);
  endproperty
  a_switch_start: assert property (p_switch_start) else $error("switch not started");

  property p_clock_output;
    cfg_valid_q && !is_crystal(cfg_q) && !clock_out_enable_n_i
      |=> !secondary_oscillator_pin_oe_n_o && secondary_oscillator_pin_o == system_clock_o;
  endproperty
  a_clock_output: assert property (p_clock_output) else $error("clock output not driven");

  property p_gain;
    cfg_valid_q && cfg_q == FOSC_XTAL_HIGH
      |=> amp_gain_o == GAIN_HIGH && secondary_oscillator_pin_oe_n_o;
  endproperty
  a_gain: assert property (p_gain) else $error("crystal gain wrong");

  property p_int_pin;
    cfg_valid_q |=> primary_pin_gpio_o == ($past(cfg_q) == FOSC_INTERNAL);
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("primary pin not released");

  property p_gpio;
    cfg_valid_q && !is_crystal(cfg_q) && clock_out_enable_n_i
      |=> secondary_oscillator_pin_oe_n_o == $past(gpio_sec_oe_n_i);
  endproperty
  a_gpio: assert property (p_gpio) else $error("secondary pin not general io");

  property p_pll_lock;
    $rose(mf_q) |-> hf_acc_q == '0 ##1 hf_acc_q == $past(hf_inc_w);
  endproperty
  a_pll_lock: assert property (p_pll_lock) else $error("pll not locked to reference");

  property p_tune;
    mf_cnt_q == mf_half_w - 1'b1 |=> mf_q != $past(mf_q) && mf_cnt_q == '0;
  endproperty
  a_tune: assert property (p_tune) else $error("tuned half period wrong");

  property p_lf;
    lf_cnt_q == LF_HALF_CYC - 1'b1 |=> lf_q != $past(lf_q) ##1 $stable(lf_q);
  endproperty
  a_lf: assert property (p_lf) else $error("low oscillator period wrong");

  property p_no_glitch;
    st_q == ST_NEW_LOW |=> !system_clock_o;
  endproperty
  a_no_glitch: assert property (p_no_glitch) else $error("clock high during switch");

  c_switch_done: cover property (st_q == ST_NEW_LOW ##1 st_q == ST_RUN);
  c_startup_done: cover property (is_crystal(cfg_q) && $rose(stup_done_w));
  c_clock_output:      cover property (!secondary_oscillator_pin_oe_n_o && $rose(secondary_oscillator_pin_o));

endmodule
`default_nettype wire

// ### core/clk_sel_pkg.sv
package clk_sel_pkg;

  // --------------------------------------------------------------------------
  // clock source configuration field encodings
  // --------------------------------------------------------------------------
  localparam logic [2:0] FOSC_XTAL_LOW  = 3'h0;
  localparam logic [2:0] FOSC_XTAL_MID  = 3'h1;
  localparam logic [2:0] FOSC_XTAL_HIGH = 3'h2;
  localparam logic [2:0] FOSC_RC        = 3'h3;
  localparam logic [2:0] FOSC_INTERNAL  = 3'h4;
  localparam logic [2:0] FOSC_EXT_LOW   = 3'h5;
  localparam logic [2:0] FOSC_EXT_MED   = 3'h6;
  localparam logic [2:0] FOSC_EXT_HIGH  = 3'h7;

  localparam logic [1:0] SEL_CONFIG    = 2'h0;
  localparam logic [1:0] SEL_SEC_TIMER = 2'h1;
  localparam int unsigned SEL_INT_BIT  = 1;

  localparam logic [1:0] INT_SEL_LF = 2'h0;
  localparam logic [1:0] INT_SEL_MF = 2'h1;

  typedef enum logic [2:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_HF, SRC_MF, SRC_LF} src_t;
  typedef enum logic [1:0] {GAIN_OFF, GAIN_LOW, GAIN_MID, GAIN_HIGH} gain_t;
  typedef enum logic [1:0] {EXT_PWR_NONE, EXT_PWR_LOW, EXT_PWR_MED, EXT_PWR_HIGH} ext_power_t;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_OLD_LOW, ST_NEW_LOW} sw_state_t;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int unsigned SYS_CLK_KHZ = 125000;
  localparam int unsigned MF_FREQ_KHZ = 500;
  localparam int unsigned HF_FREQ_KHZ = 16000;
  localparam int unsigned LF_FREQ_KHZ = 31;
  localparam int unsigned MF_HALF_INT = SYS_CLK_KHZ / (2 * MF_FREQ_KHZ);
  localparam int unsigned LF_HALF_INT = SYS_CLK_KHZ / (2 * LF_FREQ_KHZ);
  localparam int unsigned HF_INC_INT  = (HF_FREQ_KHZ * 65536 + SYS_CLK_KHZ / 2) / SYS_CLK_KHZ;

  localparam int unsigned MF_CNT_W = 8;
  localparam int unsigned LF_CNT_W = 11;
  localparam int unsigned PHASE_W  = 16;
  localparam int unsigned TUNE_W   = 6;
  localparam int unsigned HF_TUNE_SHIFT = 6;

  localparam logic [MF_CNT_W-1:0] MF_HALF_CYC  = MF_CNT_W'(MF_HALF_INT);
  localparam logic [LF_CNT_W-1:0] LF_HALF_CYC  = LF_CNT_W'(LF_HALF_INT);
  localparam logic [PHASE_W-1:0]  HF_PHASE_INC = PHASE_W'(HF_INC_INT);

  localparam int unsigned STARTUP_COUNT_DEF = 1024;
  localparam int unsigned STARTUP_CNT_W     = 11;

endpackage

// ### verif/ext_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// external oscillator or resonator on an oscillator pin
// ----------------------------------------------------------------------------
module ext_osc_model #(
  parameter int unsigned HALF_NS = 40
)(
  input  wire logic run_i,
  output logic      osc_o
);
  // offset keeps pin edges away from the sampling clock edges
  initial
  begin
    osc_o = 1'b0;
    #1.3;
    forever
    begin
      #(HALF_NS);
      // halted source rests low and gives no further edges
      osc_o = run_i ? ~osc_o : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_system_clock_source_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_select;
  import clk_sel_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        clock_output_n  = 1'b1;
  logic        gpio_out  = 1'b0;
  logic        gpio_oe_n = 1'b1;
  logic        sec_pin   = 1'b0;
  logic        pri_run   = 1'b1;
  logic [2:0]  fosc      = 3'h7;
  logic [1:0]  system_clock_select       = 2'h0;
  logic [1:0]  isel      = 2'h0;
  logic [5:0]  tune      = 6'h00;
  logic        pri_osc, sec_osc, sclk, busy, stup_en, stup_done, pgpio, spin, spin_oe_n, sin;
  src_t        src;
  gain_t       gain;
  ext_power_t  pwr;
  int          mismatches = 0;
  int          n_compared = 0;
  int          seed = 55827;
  int          meas, lo, hi, c_m;
  logic [7:0]  e_m, o_m;
  logic [7:0]  exp_q[$];
  int          code_q[$];
  event        chk;
  string       nm[11] = '{"amp_gain_o", "ext_power_o", "primary_pin_gpio_o",
    "startup_timer_en_o", "startup_done_o", "active_source_o", "switch_busy_o",
    "sec_pin_oe_n_o", "sec_pin_o", "gpio_sec_in_o", "edge_count"};
  int          sw_scs[5]  = '{1, 2, 3, 2, 0};
  int          sw_isel[5] = '{0, 2, 1, 0, 0};
  src_t        sw_src[5]  = '{SRC_SECONDARY, SRC_HF, SRC_MF, SRC_LF, SRC_PRIMARY};
  int          sw_win[5]  = '{1000, 1000, 2000, 12096, 1000};
  int          sw_lo[5]   = '{9, 126, 7, 2, 99};
  int          sw_hi[5]   = '{11, 130, 9, 4, 101};

  always #4 sys_clk_i = ~sys_clk_i;

  // --------------------------------------------------------------------------
  // design and far side
  // --------------------------------------------------------------------------
  system_clock_source_select #(.STARTUP_COUNT(4)) system_clock_source_select_i (
    .sys_clk_i                       (sys_clk_i),
    .arst_n_i                        (arst_n_i),
    .fosc_cfg_i                      (fosc),
    .clock_out_enable_n_i            (clock_output_n),
    .system_clock_select_i           (system_clock_select),
    .int_osc_select_i                (isel),
    .osc_tuning_register_i           (tune),
    .primary_oscillator_pin_i        (pri_osc),
    .sec_timer_osc_i                 (sec_osc),
    .secondary_oscillator_pin_i      (sec_pin),
    .gpio_sec_out_i                  (gpio_out),
    .gpio_sec_oe_n_i                 (gpio_oe_n),
    .system_clock_o                  (sclk),
    .active_source_o                 (src),
    .switch_busy_o                   (busy),
    .amp_gain_o                      (gain),
    .ext_power_o                     (pwr),
    .startup_timer_en_o              (stup_en),
    .startup_done_o                  (stup_done),
    .primary_pin_gpio_o              (pgpio),
    .secondary_oscillator_pin_o      (spin),
    .secondary_oscillator_pin_oe_n_o (spin_oe_n),
    .gpio_sec_in_o                   (sin)
  );
  ext_osc_model #(.HALF_NS(40)) ext_osc_model_i (.run_i(pri_run), .osc_o(pri_osc));
  ext_osc_model #(.HALF_NS(400)) ext_osc_model_sec_i (.run_i(1'b1), .osc_o(sec_osc));

  // --------------------------------------------------------------------------
  // expectation queue and its watcher
  // --------------------------------------------------------------------------
  function automatic logic [7:0] obs(int c);
    case (c)
      0: return 8'(gain);
      1: return 8'(pwr);
      2: return {7'h00, pgpio};
      3: return {7'h00, stup_en};
      4: return {7'h00, stup_done};
      5: return 8'(src);
      6: return {7'h00, busy};
      7: return {7'h00, spin_oe_n};
      8: return {7'h00, spin};
      9: return {7'h00, sin};
      10: return {7'h00, meas >= lo && meas <= hi};
      default: return 8'hff;
    endcase
  endfunction

  always @(chk)
    while (code_q.size() > 0)
    begin
      e_m = exp_q.pop_front();
      c_m = code_q.pop_front();
      o_m = obs(c_m);
      n_compared++;
      if (o_m !== e_m)
      begin
        mismatches++;
        $display("wrong value %s expected %0h seen %0h", nm[c_m], e_m, o_m);
      end
    end

  task automatic note(int c, logic [7:0] e);
    exp_q.push_back(e);
    code_q.push_back(c);
    ->chk;
    // compare before the scenario moves on and alters what obs reads
    wait (code_q.size() == 0);
  endtask

  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic do_reset(logic [2:0] cfg);
    arst_n_i = 1'b0;
    fosc     = cfg;
    repeat (6) step();
    arst_n_i = 1'b1;
  endtask

  // bounded: slowest switch is about one low-frequency half period
  task automatic wait_idle();
    int i;
    for (i = 0; i < 20000 && busy !== 1'b0; i++) step();
    note(6, 8'h00);
  endtask

  task automatic count_edges(int win, int l, int h);
    int   i;
    logic p;
    meas = 0;
    p    = sclk;
    for (i = 0; i < win; i++)
    begin
      step();
      if (sclk === 1'b1 && p === 1'b0) meas++;
      p = sclk;
    end
    lo = l;
    hi = h;
  endtask

  task automatic results();
    ->chk;
    #1;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #(8 * 60000);
    mismatches++;
    $display("watchdog expired");
    results();
  end

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    int k, c;
    for (c = 0; c < 8; c++)
    begin
      clock_output_n = 1'b1;
      do_reset(3'(c));
      repeat (3) step();
      note(0, c < 3 ? 8'(c + 1) : 8'h00);
      note(1, c > 4 ? 8'(c - 4) : 8'h00);
      note(2, {7'h00, c == 4});
      note(3, {7'h00, c < 3});
      for (k = 0; k < 3; k++)
      begin
        gpio_out  = 1'($random(seed));
        gpio_oe_n = 1'($random(seed));
        sec_pin   = 1'($random(seed));
        step();
        note(7, c < 3 ? 8'h01 : {7'h00, gpio_oe_n});
        note(8, c < 3 ? 8'h00 : {7'h00, gpio_out});
        repeat (3) step();
        if (c >= 3) note(9, {7'h00, sec_pin});
      end
      if (c != 4)
      begin
        wait_idle();
        note(5, 8'(SRC_PRIMARY));
      end
      note(4, 8'h01);
    end
    $display("test config_decode done");
    // later config changes are ignored until the next reset
    do_reset(3'h7);
    step();
    fosc     = 3'h0;
    clock_output_n = 1'b0;
    wait_idle();
    note(1, 8'(EXT_PWR_HIGH));
    note(0, 8'(GAIN_OFF));
    note(7, 8'h00);
    $display("test clock_out done");
    for (k = 0; k < 5; k++)
    begin
      system_clock_select  = 2'(sw_scs[k]);
      isel = 2'(sw_isel[k]);
      step();
      note(6, 8'h01);
      wait_idle();
      note(5, 8'(sw_src[k]));
      count_edges(sw_win[k], sw_lo[k], sw_hi[k]);
      note(10, 8'h01);
    end
    $display("test source_switch done");
    system_clock_select  = 2'h2;
    isel = 2'h2;
    wait_idle();
    tune = 6'h08;
    count_edges(1000, 134, 138);
    note(10, 8'h01);
    tune = 6'h00;
    system_clock_select  = 2'h0;
    step();
    wait_idle();
    $display("test tuning done");
    pri_run = 1'b0;
    repeat (4) step();
    count_edges(200, 0, 0);
    note(10, 8'h01);
    note(5, 8'(SRC_PRIMARY));
    note(6, 8'h00);
    pri_run = 1'b1;
    count_edges(1000, 99, 101);
    note(10, 8'h01);
    $display("test static_stop done");
    results();
  end
endmodule
`default_nettype wire
